//--- design/slave_verify_regs.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module slave_verify_regs
  import slave_verify_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire slave_event_t slave_ev,
  input wire stop_event_t stop_ev,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [2:0] ctrl;
  logic stopped;
  logic [15:0] stop_report;
  logic [15:0] out_missing;
  logic [15:0] in_missing;
  logic [15:0] out_unreg;
  logic unreg_seen;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic gen_error;
  logic restart;
  logic [15:0] ev_mask;
  logic stop_take;
  logic miss_take;
  logic unreg_take;

  // bus capture
  logic aw_held;
  logic w_held;
  logic [3:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] next_rdata;
  logic next_rerr;

  // node span to a bit mask, wrapping past node 15 is dropped
  function automatic logic [15:0] span_mask(input logic [3:0] node, input span_t span);
    logic [15:0] base;
    base = 16'h0001;
    case (span)
      SPAN_TWO: base = 16'h0003;
      SPAN_FOUR: base = 16'h000F;
      default: base = 16'h0001;
    endcase
    span_mask = base << node;
  endfunction : span_mask

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  assign ev_mask = span_mask(slave_ev.node, slave_ev.span);
  assign stop_take = stop_ev.valid && ctrl[CTRL_STOP_MODE] && !stopped;
  assign miss_take = slave_ev.miss && ctrl[CTRL_REG_ENABLE];
  assign unreg_take = slave_ev.unreg && ctrl[CTRL_REG_ENABLE];
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign restart = wr_fire && aw_idx == IDX_CTRL && w_strb[0] && w_data[CTRL_RESTART];

  // general error follows the three summary flags, no latch of its own
  assign gen_error = (|out_missing) || (|in_missing) || unreg_seen || stopped;
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // control word; restart bit is a self-clearing command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_fire && aw_idx == IDX_CTRL && w_strb[0]) begin
      ctrl <= {1'b0, w_data[CTRL_REG_ENABLE], w_data[CTRL_STOP_MODE]};
    end
  end

  // stop report: first stop wins and is held, later stops cannot overwrite;
  // a stop in the restart cycle lands only if not already stopped; a halt that arrives while stopped is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stopped <= 1'b0;
      stop_report <= WORD_RESET;
    end else if (stop_take) begin
      stopped <= 1'b1;
      stop_report <= WORD_RESET;
      stop_report[7:0] <= {4'h0, stop_ev.node};
      stop_report[STOP_KIND_BIT] <= stop_ev.is_input;
    end else if (restart) begin
      stopped <= 1'b0;
      stop_report <= WORD_RESET;
    end
    // bits 14:8 never written, stay zero held otherwise
  end

  // missing flags: a join or restart clears, a miss in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_missing <= WORD_RESET;
      in_missing <= WORD_RESET;
    end else begin
      if (restart) begin
        out_missing <= WORD_RESET;
        in_missing <= WORD_RESET;
      end else if (slave_ev.join_net && !miss_take) begin
        if (slave_ev.is_input) begin
          in_missing <= in_missing & ~ev_mask;
        end else begin
          out_missing <= out_missing & ~ev_mask;
        end
      end
      // later assignment overrides, so the set beats both clears
      if (miss_take && !slave_ev.is_input) begin
        out_missing <= (restart ? WORD_RESET : out_missing) | ev_mask;
      end
      if (miss_take && slave_ev.is_input) begin
        in_missing <= (restart ? WORD_RESET : in_missing) | ev_mask;
      end
    end
  end

  // unregistered output slaves: sticky until restart; an arrival in the
  // restart cycle still lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_unreg <= WORD_RESET;
      unreg_seen <= 1'b0;
    end else if (unreg_take) begin
      unreg_seen <= 1'b1;
      if (!slave_ev.is_input) begin
        out_unreg <= (restart ? WORD_RESET : out_unreg) | ev_mask;
      end else if (restart) begin
        out_unreg <= WORD_RESET;
      end
    end else if (restart) begin
      out_unreg <= WORD_RESET;
      unreg_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((wr_fire && aw_idx == IDX_IRQ_STATUS && w_strb[0]) ?
                     w_data[IRQ_BITS-1:0] : '0)) |
                    {unreg_take, miss_take, stop_take};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= '0;
    end else if (wr_fire && aw_idx == IDX_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[IRQ_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channels taken in either order, one write under way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[5:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  // write response; only control, interrupt status and mask take writes, other words answer an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_idx == IDX_CTRL || aw_idx == IDX_IRQ_STATUS ||
                      aw_idx == IDX_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr[5:2])
      IDX_CTRL: next_rdata = {30'h0, ctrl[1:0]};
      IDX_GEN_FLAGS: begin
        next_rdata[GEN_MISSING] = (|out_missing) || (|in_missing);
        next_rdata[GEN_UNREG] = unreg_seen;
        next_rdata[GEN_STOPPED] = stopped;
        next_rdata[GEN_ERROR] = gen_error;
      end
      IDX_STOP_REPORT: next_rdata = {16'h0, stop_report};
      IDX_OUT_MISSING: next_rdata = {16'h0, out_missing};
      IDX_IN_MISSING: next_rdata = {16'h0, in_missing};
      IDX_OUT_UNREG: next_rdata = {16'h0, out_unreg};
      IDX_IRQ_STATUS: next_rdata = {29'h0, irq_status};
      IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      default: next_rerr = 1'b1;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_stop_node_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_take |=> stop_report[7:0] == {4'h0, $past(stop_ev.node)})
    else $error("stop node not latched");
  a_stop_held: assert property (@(posedge aclk) disable iff (!aresetn)
    stopped && !restart |=> $stable(stop_report))
    else $error("stop report changed while stopped");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_report[14:8] == 7'h00)
    else $error("reserved stop bits set");
  a_stop_kind: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_take |=> stop_report[STOP_KIND_BIT] == $past(stop_ev.is_input))
    else $error("stop kind wrong");
  a_kind_held: assert property (@(posedge aclk) disable iff (!aresetn)
    stopped && !restart |=> $stable(stop_report[STOP_KIND_BIT]) && stopped)
    else $error("stop kind not held");
  a_out_miss_set: assert property (@(posedge aclk) disable iff (!aresetn)
    miss_take && !slave_ev.is_input |=>
    (out_missing & $past(ev_mask)) == $past(ev_mask))
    else $error("output missing bits not set");
  a_out_join_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_ev.join_net && !miss_take && !slave_ev.is_input |=>
    (out_missing & $past(ev_mask)) == 16'h0000)
    else $error("output missing bits not cleared");
  a_in_miss_set: assert property (@(posedge aclk) disable iff (!aresetn)
    miss_take && slave_ev.is_input |=>
    (in_missing & $past(ev_mask)) == $past(ev_mask))
    else $error("input missing bits not set");
  a_in_join_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_ev.join_net && !miss_take && slave_ev.is_input |=>
    (in_missing & $past(ev_mask)) == 16'h0000)
    else $error("input missing bits not cleared");
  a_span_four: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_ev.span == SPAN_FOUR && slave_ev.node < 4'hD |-> $countones(ev_mask) == 4)
    else $error("32-point span not four bits");
  a_error_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_take || miss_take || unreg_take |=> gen_error)
    else $error("general error flag not raised");
  a_restart_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    restart && !stop_take && !miss_take |=>
    stop_report == 16'h0 && out_missing == 16'h0 && in_missing == 16'h0)
    else $error("restart did not clear");
  // a stop event in the cycle of a write-one-to-clear must not be lost
  a_irq_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_take |=> irq_status[IRQ_STOP])
    else $error("stop interrupt lost");

  c_stop_seen: cover property (@(posedge aclk) disable iff (!aresetn) stop_take);
  c_miss_then_join: cover property (@(posedge aclk) disable iff (!aresetn)
    miss_take ##[1:20] slave_ev.join_net);
  c_irq_raised: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_restart: cover property (@(posedge aclk) disable iff (!aresetn) restart && stopped);

endmodule : slave_verify_regs

//--- design/slave_verify_pkg.sv
package slave_verify_pkg;

  // register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_GEN_FLAGS = 4'h4;
  localparam logic [3:0] IDX_STOP_REPORT = 4'h5;
  localparam logic [3:0] IDX_OUT_MISSING = 4'h6;
  localparam logic [3:0] IDX_IN_MISSING = 4'h7;
  localparam logic [3:0] IDX_OUT_UNREG = 4'h8;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'hA;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hB;

  // control word fields
  localparam int CTRL_STOP_MODE = 0;
  localparam int CTRL_REG_ENABLE = 1;
  localparam int CTRL_RESTART = 2;

  // general flag word fields, and the stop report kind bit
  localparam int GEN_MISSING = 8;
  localparam int GEN_UNREG = 9;
  localparam int GEN_STOPPED = 10;
  localparam int GEN_ERROR = 15;
  localparam int STOP_KIND_BIT = 15;

  // interrupt event fields
  localparam int IRQ_STOP = 0;
  localparam int IRQ_MISSING = 1;
  localparam int IRQ_UNREG = 2;
  localparam int IRQ_BITS = 3;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // slave size codes: how many node numbers a slave spans
  typedef enum logic [1:0] {SPAN_ONE, SPAN_TWO, SPAN_FOUR} span_t;

  typedef struct packed {
    logic miss;     // registered slave found absent
    logic join_net; // slave has joined the network
    logic unreg;    // unregistered slave has joined
    logic is_input; // 0 output slave, 1 input slave
    logic [3:0] node;
    span_t span;
  } slave_event_t;

  typedef struct packed {
    logic valid;    // communications halted by an error
    logic is_input;
    logic [3:0] node;
  } stop_event_t;

endpackage : slave_verify_pkg

//--- dv/net_model.sv
`timescale 1ns/1ps
module net_model
  import slave_verify_pkg::*;
(
  input wire logic aclk,
  output slave_event_t slave_ev,
  output stop_event_t stop_ev
);
  // quiet network between reports
  initial begin
    slave_ev = '0;
    stop_ev = '0;
  end
  ////////////////////////////////////////////////////////////////
  // kind is miss, join, unreg, input; one edge only, as slaves report
  task automatic report(input logic [3:0] kind, input logic [3:0] node, input span_t span);
    @(posedge aclk);
    slave_ev <= {kind, node, span};
    @(posedge aclk);
    slave_ev <= '0;
  endtask : report
  // halt notice from a failing slave, also a single-edge pulse
  task automatic halt(input logic is_input, input logic [3:0] node);
    @(posedge aclk);
    stop_ev <= {1'b1, is_input, node};
    @(posedge aclk);
    stop_ev <= '0;
  endtask : halt
endmodule : net_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import slave_verify_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  slave_event_t slave_ev;
  stop_event_t stop_ev;
  int num_errors = 0, check_count = 0, cycles = 0;

  // 50 MHz
  always #10 aclk = ~aclk;

  slave_verify_regs u_slave_verify_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slave_ev(slave_ev), .stop_ev(stop_ev), .irq(irq));
  net_model u_net_model (.aclk(aclk), .slave_ev(slave_ev), .stop_ev(stop_ev));

  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // a hang in any handshake ends here
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: data %h, want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: resp %h, want %h", $time, got, exp);
    end
  endtask : chk_resp

  // irq is combinational, so look at it mid-cycle
  task automatic chk_irq(input logic exp);
    @(negedge aclk);
    check_count++;
    if (irq !== exp) begin
      num_errors++;
      $display("Error %0t: irq %b, want %b", $time, irq, exp);
    end
  endtask : chk_irq

  ////////////////////////////////////////////////////////////////
  // handshakes judged at the negedge; values hold until the next rise
  task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    b_hs = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk_resp(r, er);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    r_hs = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, exp);
    chk_resp(r, er);
  endtask : rd

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(IDX_GEN_FLAGS, 32'h0, RESP_OKAY);
    rd(IDX_STOP_REPORT, 32'h0, RESP_OKAY);
    rd(IDX_OUT_MISSING, 32'h0, RESP_OKAY);
    rd(IDX_IN_MISSING, 32'h0, RESP_OKAY);
    rd(IDX_OUT_UNREG, 32'h0, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    wr(IDX_CTRL, 32'h7, RESP_OKAY);
    rd(IDX_CTRL, 32'h3, RESP_OKAY);
    wr(IDX_STOP_REPORT, 32'hFFFF, RESP_SLVERR);
    rd(IDX_STOP_REPORT, 32'h0, RESP_OKAY);
    rd(4'hF, 32'h0, RESP_SLVERR);
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
  endtask : t_reset

  task automatic t_missing;
    u_net_model.report(4'b1000, 4'h3, SPAN_TWO);
    rd(IDX_OUT_MISSING, 32'h0, RESP_OKAY);
    wr(IDX_CTRL, 32'h2, RESP_OKAY);
    u_net_model.report(4'b1000, 4'h3, SPAN_TWO);
    u_net_model.report(4'b1000, 4'h0, SPAN_ONE);
    rd(IDX_OUT_MISSING, 32'h0019, RESP_OKAY);
    u_net_model.report(4'b1001, 4'hE, SPAN_FOUR);
    u_net_model.report(4'b1001, 4'h4, SPAN_FOUR);
    rd(IDX_IN_MISSING, 32'hC0F0, RESP_OKAY);
    rd(IDX_GEN_FLAGS, 32'h8100, RESP_OKAY);
    u_net_model.report(4'b0100, 4'h3, SPAN_TWO);
    rd(IDX_OUT_MISSING, 32'h0001, RESP_OKAY);
    u_net_model.report(4'b1100, 4'h5, SPAN_ONE);
    rd(IDX_OUT_MISSING, 32'h0021, RESP_OKAY);
    u_net_model.report(4'b0100, 4'h5, SPAN_ONE);
    u_net_model.report(4'b0100, 4'h0, SPAN_ONE);
    u_net_model.report(4'b0101, 4'hE, SPAN_FOUR);
    rd(IDX_IN_MISSING, 32'h00F0, RESP_OKAY);
    u_net_model.report(4'b0101, 4'h4, SPAN_FOUR);
    rd(IDX_IN_MISSING, 32'h0, RESP_OKAY);
    rd(IDX_GEN_FLAGS, 32'h0, RESP_OKAY);
  endtask : t_missing

  task automatic t_irq;
    chk_irq(1'b0);
    wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
    chk_irq(1'b1);
    wr(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
    chk_irq(1'b0);
    u_net_model.report(4'b0010, 4'h1, SPAN_ONE);
    rd(IDX_OUT_UNREG, 32'h0002, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 32'h4, RESP_OKAY);
    chk_irq(1'b0);
    rd(IDX_GEN_FLAGS, 32'h8200, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
  endtask : t_irq

  task automatic t_stop;
    u_net_model.halt(1'b1, 4'hC);
    rd(IDX_STOP_REPORT, 32'h0, RESP_OKAY);
    wr(IDX_CTRL, 32'h3, RESP_OKAY);
    u_net_model.halt(1'b1, 4'hC);
    rd(IDX_STOP_REPORT, 32'h800C, RESP_OKAY);
    u_net_model.halt(1'b0, 4'h2);
    rd(IDX_STOP_REPORT, 32'h800C, RESP_OKAY);
    rd(IDX_GEN_FLAGS, 32'h8600, RESP_OKAY);
    wr(IDX_CTRL, 32'h5, RESP_OKAY);
    rd(IDX_STOP_REPORT, 32'h0, RESP_OKAY);
    rd(IDX_OUT_UNREG, 32'h0, RESP_OKAY);
    u_net_model.halt(1'b0, 4'hF);
    rd(IDX_STOP_REPORT, 32'h000F, RESP_OKAY);
  endtask : t_stop

  // reset for four edges, then every scenario in turn
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_missing();
    t_irq();
    t_stop();
    test_done();
  end
endmodule : tb_top
